/* File: test/sdram_bank_command_rules_tb.sv */
// Self-checking bench for the bank command tracker
`timescale 1ns/1ps
module sdram_bank_command_rules_tb;
   localparam logic [23:0] IDLE4 = 24'h04_1041;
   localparam logic [2:0] ACT = sdram_cmd_pkg::CODE_ACTIVE;
   localparam logic [2:0] PRE = sdram_cmd_pkg::CODE_PRECHARGE;
   localparam logic [2:0] REF = sdram_cmd_pkg::CODE_REFRESH;
   localparam logic [2:0] NOP = sdram_cmd_pkg::CODE_NOP;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   wire cke, cs_n, ap, all_idle_out, illegal_cmd_out, power_down_out, self_refresh_out, busy_out;
   wire [2:0] code;
   wire [1:0] bank;
   wire [1:0] burst_bank_out;
   wire [23:0] bank_state_out;
   wire [3:0] close_start_out;
   int err_count = 0;
   int n_tests = 0;

   always #5 clk_in = ~clk_in;

   sdram_ctl_model u_ctl (.clk_in(clk_in), .cke_out(cke), .cs_n_out(cs_n), .code_out(code),
      .bank_out(bank), .ap_out(ap));
   sdram_bank_command_rules u_dut (.clk_in(clk_in), .srst_in(srst_in), .cke_in(cke),
      .cs_n_in(cs_n), .ras_n_in(code[2]), .cas_n_in(code[1]), .we_n_in(code[0]),
      .bank_in(bank), .auto_close_row_in(ap), .bank_state_out(bank_state_out),
      .all_idle_out(all_idle_out), .burst_bank_out(burst_bank_out),
      .close_start_out(close_start_out),
      .illegal_cmd_out(illegal_cmd_out), .power_down_out(power_down_out),
      .self_refresh_out(self_refresh_out), .busy_out(busy_out));

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Bank state by index; index 4 reads the busy flag instead
   function automatic logic [5:0] probe(input int b);
      return (b < 4) ? bank_state_out[6*b +: 6] : {5'h00, busy_out};
   endfunction : probe

   task automatic c(input logic [2:0] k, input int b, input logic a = 1'b0,
         input logic s = 1'b1, input logic ck = 1'b1);
      u_ctl.cmd(k, b[1:0], a, s, ck);
   endtask : c

   // Wait for a state, then count how many cycles it holds
   task automatic watch(input int b, input logic [5:0] s, input int exp_n, input string name);
      int n;
      int k;
      n = 0;
      #1;
      for (k = 0; k < 8 && probe(b) !== s; k++) begin
         @(posedge clk_in);
         #1;
      end
      while (probe(b) === s && n < 40) begin
         n++;
         @(posedge clk_in);
         #1;
      end
      check(name, n, exp_n);
   endtask : watch

   // Gather pulse outputs over four cycles, from just after the command edge,
   // where one-cycle pulses stand; bank 0 state taken at the first
   task automatic pulses(output logic [3:0] cs, output logic il, output logic [5:0] s0);
      cs = 4'h0;
      il = 1'b0;
      for (int k = 0; k < 4; k++) begin
         #1;
         if (k == 0) s0 = probe(0);
         cs = cs | close_start_out;
         il = il | illegal_cmd_out;
         if (k < 3) @(posedge clk_in);
      end
   endtask : pulses

   // Activate then auto-close read; no-ops between keep each phase running
   task automatic t_basic();
      c(ACT, 0);
      watch(0, sdram_cmd_pkg::BANK_ACTIVATING, sdram_cmd_pkg::RCD_CYC, "activating");
      c(sdram_cmd_pkg::CODE_READ, 0, 1'b1);
      watch(0, sdram_cmd_pkg::BANK_READING, sdram_cmd_pkg::BURST_LEN, "reading");
      watch(0, sdram_cmd_pkg::BANK_PRECHARGING, sdram_cmd_pkg::RP_CYC, "read close");
      check("idle after read", probe(0), sdram_cmd_pkg::BANK_IDLE);
   endtask : t_basic

   // Auto-close write: two recovery cycles are added before the precharge time
   task automatic t_write_ap();
      c(ACT, 2);
      watch(2, sdram_cmd_pkg::BANK_ACTIVATING, sdram_cmd_pkg::RCD_CYC, "act 2");
      c(sdram_cmd_pkg::CODE_WRITE, 2, 1'b1);
      watch(2, sdram_cmd_pkg::BANK_WRITING, sdram_cmd_pkg::BURST_LEN, "writing");
      watch(2, sdram_cmd_pkg::BANK_PRECHARGING, 2 + sdram_cmd_pkg::RP_CYC, "wr close");
   endtask : t_write_ap

   // Auto-close write cut early by a read elsewhere; precharge elsewhere mid-write
   task automatic t_cut();
      logic [3:0] cs;
      logic il;
      logic [5:0] s0;
      c(ACT, 0);
      c(ACT, 1);
      c(ACT, 3);
      watch(3, sdram_cmd_pkg::BANK_ACTIVATING, sdram_cmd_pkg::RCD_CYC, "act 3");
      c(sdram_cmd_pkg::CODE_WRITE, 0, 1'b1);
      // No write data follows the cut, so nothing is left unmasked
      c(sdram_cmd_pkg::CODE_READ, 1);
      pulses(cs, il, s0);
      check("cut bank", s0, sdram_cmd_pkg::BANK_PRECHARGING);
      check("cut pulse", cs, 4'h1);
      check("cut legal", il, 1'b0);
      c(sdram_cmd_pkg::CODE_WRITE, 1, 1'b1);
      c(PRE, 3);
      watch(3, sdram_cmd_pkg::BANK_PRECHARGING, sdram_cmd_pkg::RP_CYC, "pre 3");
   endtask : t_cut

   // Burst stop aimed at another bank still ends the running burst; refresh rules
   task automatic t_stop_refresh();
      logic [3:0] cs;
      logic il;
      logic [5:0] s0;
      c(ACT, 2);
      watch(2, sdram_cmd_pkg::BANK_ACTIVATING, sdram_cmd_pkg::RCD_CYC, "act 2b");
      c(sdram_cmd_pkg::CODE_READ, 2);
      c(sdram_cmd_pkg::CODE_BURST_STOP, 0);
      @(posedge clk_in);
      #1;
      check("stopped", probe(2), sdram_cmd_pkg::BANK_ACTIVE);
      check("stop bank", burst_bank_out, 2'h2);
      c(ACT, 2);
      pulses(cs, il, s0);
      check("act open row", {il, probe(2)}, {1'b1, sdram_cmd_pkg::BANK_ACTIVE});
      c(REF, 0);
      pulses(cs, il, s0);
      check("refresh open", {il, busy_out}, 2'h2);
      c(PRE, 0, 1'b1);
      watch(2, sdram_cmd_pkg::BANK_PRECHARGING, sdram_cmd_pkg::RP_CYC, "pre all");
      check("all idle", bank_state_out, IDLE4);
      c(REF, 0);
      watch(4, 6'h01, sdram_cmd_pkg::RC_CYC, "refresh busy");
      c(sdram_cmd_pkg::CODE_MODE_SET, 0);
      watch(4, 6'h01, sdram_cmd_pkg::MRD_CYC, "mode busy");
   endtask : t_stop_refresh

   // Deselect, self refresh, power down: commands count only with clock enable high twice, bar self refresh entry on clock enable falling
   task automatic t_cke();
      c(ACT, 1, 1'b0, 1'b0);
      repeat (3) @(posedge clk_in);
      #1;
      check("deselect", bank_state_out, IDLE4);
      c(REF, 0, 1'b0, 1'b1, 1'b0);
      repeat (2) @(posedge clk_in);
      #1;
      check("self refresh", self_refresh_out, 1'b1);
      c(NOP, 0, 1'b0, 1'b1, 1'b1);
      watch(4, 6'h01, sdram_cmd_pkg::RC_CYC, "exit wait");
      c(NOP, 0, 1'b0, 1'b1, 1'b0);
      c(ACT, 0, 1'b0, 1'b1, 1'b0);
      @(posedge clk_in);
      #1;
      check("power down", power_down_out, 1'b1);
      c(NOP, 0);
      repeat (3) @(posedge clk_in);
      #1;
      check("pd ignored", {power_down_out, bank_state_out}, {1'b0, IDLE4});
   endtask : t_cke

   task automatic summarize();
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // Reset for five cycles, raise clock enable, then the scenarios
   initial begin
      repeat (5) @(posedge clk_in);
      srst_in <= 1'b0;
      c(NOP, 0);
      #1;
      check("reset", {all_idle_out, bank_state_out}, {1'b1, IDLE4});
      t_basic();
      t_write_ap();
      t_cut();
      t_stop_refresh();
      t_cke();
      summarize();
   end

   // Whole run needs about 130 cycles; this limit cuts a hang short
   initial begin
      repeat (3000) @(posedge clk_in);
      err_count++;
      summarize();
   end
endmodule : sdram_bank_command_rules_tb

/* File: test/sdram_ctl_model.sv */
// Controller model that drives one command per edge onto the device pins
`timescale 1ns/1ps
module sdram_ctl_model (
   input wire logic clk_in,
   output logic cke_out,
   output logic cs_n_out,
   output logic [2:0] code_out,
   output logic [1:0] bank_out,
   output logic ap_out
);
   // Quiet pins at time zero; clock enable stays low until the first command
   initial begin
      cke_out = 1'b0;
      cs_n_out = 1'b1;
      code_out = sdram_cmd_pkg::CODE_NOP;
      bank_out = 2'h0;
      ap_out = 1'b0;
   end

   // One command for one edge, then no-op; clock enable is left where it was put
   task automatic cmd(input logic [2:0] code, input logic [1:0] b, input logic a,
         input logic sel, input logic ck);
      @(posedge clk_in);
      cke_out <= ck;
      cs_n_out <= ~sel;
      code_out <= code;
      bank_out <= b;
      ap_out <= a;
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      code_out <= sdram_cmd_pkg::CODE_NOP;
   endtask : cmd
endmodule : sdram_ctl_model

/* File: test/sdram_rules_checker.sv */
// Concurrent checks on the ports of the bank command tracker
`timescale 1ns/1ps
module sdram_rules_checker (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic cke_in,
   input wire logic cs_n_in,
   input wire logic [23:0] bank_state_out,
   input wire logic all_idle_out,
   input wire logic [3:0] close_start_out,
   input wire logic illegal_cmd_out,
   input wire logic power_down_out,
   input wire logic self_refresh_out,
   input wire logic busy_out
);
   localparam logic [23:0] IDLE4 = 24'h04_1041;
   logic [5:0] st0;
   assign st0 = bank_state_out[5:0];
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // Bank 0 phase runs used by the timing properties
   sequence act_run;
      (st0 == sdram_cmd_pkg::BANK_ACTIVATING) [*3];
   endsequence
   sequence prech_run;
      (st0 == sdram_cmd_pkg::BANK_PRECHARGING) [*3];
   endsequence

   a_state_onehot: assert property ($onehot(st0) && $onehot(bank_state_out[11:6])
      && $onehot(bank_state_out[17:12]) && $onehot(bank_state_out[23:18]))
      else $error("bank state not one-hot");
   a_idle_flag: assert property (all_idle_out == $past(bank_state_out == IDLE4))
      else $error("all idle flag wrong");
   a_act_bound: assert property (act_run |=> st0 != sdram_cmd_pkg::BANK_ACTIVATING)
      else $error("activating too long");
   a_prech_min: assert property ($rose(st0 == sdram_cmd_pkg::BANK_PRECHARGING) |-> prech_run)
      else $error("precharging too short");
   a_close_state: assert property (close_start_out[0] |->
      st0 inside {sdram_cmd_pkg::BANK_PRECHARGING, sdram_cmd_pkg::BANK_ACTIVE})
      else $error("cut burst did not leave bank");
   a_busy_idle: assert property (busy_out |-> all_idle_out && bank_state_out == IDLE4)
      else $error("busy with a bank open");
   a_busy_bound: assert property (busy_out [*8] |-> 1'b0)
      else $error("busy too long");
   a_illegal_cause: assert property (illegal_cmd_out |->
      !$past(cs_n_in))
      else $error("illegal flag without a selected command");
   a_pd_entry: assert property ($rose(power_down_out) |->
      !$past(cke_in, 2) || !$past(cke_in, 3))
      else $error("power down without clock enable low");
   a_selfref_idle: assert property (self_refresh_out |-> bank_state_out == IDLE4)
      else $error("self refresh with a bank open");
endmodule : sdram_rules_checker

bind sdram_bank_command_rules sdram_rules_checker u_chk (.clk_in(clk_in), .srst_in(srst_in),
   .cke_in(cke_in), .cs_n_in(cs_n_in), .bank_state_out(bank_state_out),
   .all_idle_out(all_idle_out), .close_start_out(close_start_out),
   .illegal_cmd_out(illegal_cmd_out), .power_down_out(power_down_out),
   .self_refresh_out(self_refresh_out), .busy_out(busy_out));

/* File: verilog/bank_tracker.sv */
// One bank's row and burst state with its timing counter
`timescale 1ns/1ps
module bank_tracker (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic activate_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic auto_close_row_in,
   input wire logic precharge_in,
   input wire logic burst_stop_in,
   input wire logic interrupt_in,
   output sdram_cmd_pkg::bank_state_t state_out
);
   logic [sdram_cmd_pkg::CNT_W-1:0] cnt_reg;
   logic auto_reg;
   logic cnt_done;

   assign cnt_done = (cnt_reg == sdram_cmd_pkg::CNT_ZERO);

   // Bank state and its timer; own commands outrank a cut from another bank
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_out <= sdram_cmd_pkg::BANK_IDLE;
         cnt_reg <= sdram_cmd_pkg::CNT_ZERO;
         auto_reg <= 1'b0;
      end else begin
         if (!cnt_done) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
         case (state_out)
            sdram_cmd_pkg::BANK_IDLE: begin
               if (activate_in) begin
                  state_out <= sdram_cmd_pkg::BANK_ACTIVATING;
                  cnt_reg <= sdram_cmd_pkg::LD_RCD;
               end
            end
            sdram_cmd_pkg::BANK_ACTIVATING: begin
               if (precharge_in) begin
                  state_out <= sdram_cmd_pkg::BANK_PRECHARGING;
                  cnt_reg <= sdram_cmd_pkg::LD_RP;
               end else if (cnt_done) begin
                  state_out <= sdram_cmd_pkg::BANK_ACTIVE;
               end
            end
            sdram_cmd_pkg::BANK_ACTIVE,
            sdram_cmd_pkg::BANK_READING,
            sdram_cmd_pkg::BANK_WRITING: begin
               if (read_in || write_in) begin
                  state_out <= read_in ? sdram_cmd_pkg::BANK_READING
                                       : sdram_cmd_pkg::BANK_WRITING;
                  cnt_reg <= sdram_cmd_pkg::LD_BURST;
                  auto_reg <= auto_close_row_in;
               end else if (precharge_in) begin
                  state_out <= sdram_cmd_pkg::BANK_PRECHARGING;
                  cnt_reg <= sdram_cmd_pkg::LD_RP;
               end else if (state_out != sdram_cmd_pkg::BANK_ACTIVE &&
                            (burst_stop_in || interrupt_in || cnt_done)) begin
                  // Burst over; an auto-close burst starts closing here
                  if (auto_reg) begin
                     state_out <= sdram_cmd_pkg::BANK_PRECHARGING;
                     // Written data needs recovery before the row can close
                     cnt_reg <= (state_out == sdram_cmd_pkg::BANK_WRITING)
                                ? sdram_cmd_pkg::LD_WR_RP : sdram_cmd_pkg::LD_RP;
                  end else begin
                     state_out <= sdram_cmd_pkg::BANK_ACTIVE;
                  end
               end
            end
            sdram_cmd_pkg::BANK_PRECHARGING: begin
               if (cnt_done) begin
                  state_out <= sdram_cmd_pkg::BANK_IDLE;
                  auto_reg <= 1'b0;
               end
            end
            default: begin
               state_out <= sdram_cmd_pkg::BANK_IDLE;
            end
         endcase
      end
   end
endmodule : bank_tracker

/* File: verilog/sdram_bank_command_rules.sv */
// Command decoder and bank state tracker at the command pins of a four-bank SDRAM
//
// What this block does
// - Commands count only with clock enable high twice, except self refresh entry on clock enable falling
// - Burst stop acts on the running burst only
// - Interrupted auto-close burst starts closing its bank
// - Clock enable sampled each edge with previous level
// - Chip select high is deselect, operation continues
// - No-op command continues operation in progress
`timescale 1ns/1ps
module sdram_bank_command_rules (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic cke_in,
   input wire logic cs_n_in,
   input wire logic ras_n_in,
   input wire logic cas_n_in,
   input wire logic we_n_in,
   input wire logic [1:0] bank_in,
   input wire logic auto_close_row_in,
   output logic [23:0] bank_state_out,
   output logic all_idle_out,
   output logic [1:0] burst_bank_out,
   output logic [3:0] close_start_out,
   output logic illegal_cmd_out,
   output logic power_down_out,
   output logic self_refresh_out,
   output logic busy_out
);
   sdram_cmd_pkg::dev_state_t dev_reg;
   sdram_cmd_pkg::bank_state_t bank_state [sdram_cmd_pkg::NUM_BANKS];
   logic cke_prev_reg;
   logic [sdram_cmd_pkg::CNT_W-1:0] dev_cnt_reg;
   logic [sdram_cmd_pkg::BANK_W-1:0] burst_bank_reg;
   logic [2:0] code;
   logic cmd_ok;
   // Decoded commands, already qualified by clock enable and chip select
   logic do_act, do_rd, do_wr, do_pre, do_ref, do_mrs, do_stop;
   logic all_idle, any_burst, sr_entry, pd_entry, ref_bad, bank_bad;
   // Per-bank strobes and status vectors, one bit per bank
   logic [sdram_cmd_pkg::NUM_BANKS-1:0] act_v, rd_v, wr_v, pre_v, stop_v, cut_v;
   logic [sdram_cmd_pkg::NUM_BANKS-1:0] idle_v, burst_v, close_v, bad_v;

   // Previous clock enable level, sampled every edge
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cke_prev_reg <= 1'b0;
      end else begin
         cke_prev_reg <= cke_in;
      end
   end

   // Command decode; deselect and no-op fall through and change nothing
   assign code = {ras_n_in, cas_n_in, we_n_in};
   assign cmd_ok = cke_prev_reg && cke_in && !cs_n_in &&
                   (dev_reg == sdram_cmd_pkg::DEV_NORMAL);
   assign do_act = cmd_ok && (code == sdram_cmd_pkg::CODE_ACTIVE);
   assign do_rd = cmd_ok && (code == sdram_cmd_pkg::CODE_READ);
   assign do_wr = cmd_ok && (code == sdram_cmd_pkg::CODE_WRITE);
   assign do_pre = cmd_ok && (code == sdram_cmd_pkg::CODE_PRECHARGE);
   assign do_ref = cmd_ok && (code == sdram_cmd_pkg::CODE_REFRESH) && all_idle;
   assign do_mrs = cmd_ok && (code == sdram_cmd_pkg::CODE_MODE_SET) && all_idle;
   assign do_stop = cmd_ok && (code == sdram_cmd_pkg::CODE_BURST_STOP);
   // No-op code matches none of the strobes above and so does nothing

   // Self refresh entry: refresh code with clock enable falling; else power down
   assign sr_entry = cke_prev_reg && !cke_in && !cs_n_in && all_idle &&
                     (code == sdram_cmd_pkg::CODE_REFRESH);
   // A running burst blocks power down; the burst simply carries on
   assign pd_entry = cke_prev_reg && !cke_in && !sr_entry && !any_burst;

   // Per-bank strobes and status
   genvar b;
   generate
      for (b = 0; b < sdram_cmd_pkg::NUM_BANKS; b++) begin : g_bank
         logic hit;
         logic closed_row;
         assign hit = (bank_in == sdram_cmd_pkg::BANK_W'(b));
         assign act_v[b] = do_act && hit;
         assign rd_v[b] = do_rd && hit;
         assign wr_v[b] = do_wr && hit;
         // Row address bit selects all banks on precharge
         assign pre_v[b] = do_pre && (hit || auto_close_row_in);
         // Burst stop goes to the latest burst, whatever bank was named
         assign stop_v[b] = do_stop && (burst_bank_reg == sdram_cmd_pkg::BANK_W'(b));
         // A legal read or write elsewhere cuts this bank's burst; a refused
         // access executes nothing, so other bursts keep running
         assign cut_v[b] = (do_rd || do_wr) && !hit && !bank_bad;
         // Status of this bank as the decoder sees it ahead of the edge
         assign idle_v[b] = (bank_state[b] == sdram_cmd_pkg::BANK_IDLE);
         assign burst_v[b] = (bank_state[b] == sdram_cmd_pkg::BANK_READING) ||
                             (bank_state[b] == sdram_cmd_pkg::BANK_WRITING);
         // Any burst that is cut ahead of its end pulses here; an auto-close one begins closing now
         assign close_v[b] = burst_v[b] && cut_v[b] && !pre_v[b];
         // No row open yet, or one already closing, takes no column access
         assign closed_row = idle_v[b] ||
                             (bank_state[b] == sdram_cmd_pkg::BANK_ACTIVATING) ||
                             (bank_state[b] == sdram_cmd_pkg::BANK_PRECHARGING);
         // Bank-level illegal pairs: activate on a bank not idle, access on closed row
         assign bad_v[b] = (act_v[b] && !idle_v[b]) ||
                           ((rd_v[b] || wr_v[b]) && closed_row);

         bank_tracker u_bank (
            .clk_in(clk_in),
            .srst_in(srst_in),
            .activate_in(act_v[b] && idle_v[b]),
            .read_in(rd_v[b] && !bad_v[b]),
            .write_in(wr_v[b] && !bad_v[b]),
            .auto_close_row_in(auto_close_row_in),
            .precharge_in(pre_v[b]),
            .burst_stop_in(stop_v[b]),
            .interrupt_in(cut_v[b]),
            .state_out(bank_state[b])
         );
         assign bank_state_out[b*sdram_cmd_pkg::BANK_ST_W +: sdram_cmd_pkg::BANK_ST_W] =
            bank_state[b];
      end
   endgenerate

   // Device-wide summaries of the bank states
   assign all_idle = &idle_v;
   assign any_burst = |burst_v;
   assign ref_bad = cmd_ok && !all_idle && ((code == sdram_cmd_pkg::CODE_REFRESH) ||
                    (code == sdram_cmd_pkg::CODE_MODE_SET));
   assign bank_bad = |bad_v;

   // Bank of the most recent burst, the target of a later burst stop;
   // a refused access starts no burst, so it must not move the target
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         burst_bank_reg <= '0;
      end else if ((do_rd || do_wr) && !bank_bad) begin
         burst_bank_reg <= bank_in;
      end
   end
   assign burst_bank_out = burst_bank_reg;

   // Device-wide state: refresh, mode set, power down and self refresh
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         dev_reg <= sdram_cmd_pkg::DEV_NORMAL;
         dev_cnt_reg <= sdram_cmd_pkg::CNT_ZERO;
      end else begin
         if (dev_cnt_reg != sdram_cmd_pkg::CNT_ZERO) begin
            dev_cnt_reg <= dev_cnt_reg - 1'b1;
         end
         case (dev_reg)
            sdram_cmd_pkg::DEV_NORMAL: begin
               // Self refresh entry outranks power down; both need clock enable falling
               if (sr_entry) begin
                  dev_reg <= sdram_cmd_pkg::DEV_SELF_REFRESH;
               end else if (pd_entry) begin
                  dev_reg <= sdram_cmd_pkg::DEV_POWER_DOWN;
               end else if (do_ref) begin
                  dev_reg <= sdram_cmd_pkg::DEV_REFRESHING;
                  dev_cnt_reg <= sdram_cmd_pkg::LD_RC;
               end else if (do_mrs) begin
                  dev_reg <= sdram_cmd_pkg::DEV_MODE_SETTING;
                  dev_cnt_reg <= sdram_cmd_pkg::LD_MRD;
               end
            end
            sdram_cmd_pkg::DEV_REFRESHING,
            sdram_cmd_pkg::DEV_MODE_SETTING,
            sdram_cmd_pkg::DEV_SELF_REFRESH_EXIT: begin
               // Commands here are dropped; only deselect or no-op are expected
               if (dev_cnt_reg == sdram_cmd_pkg::CNT_ZERO) begin
                  dev_reg <= sdram_cmd_pkg::DEV_NORMAL;
               end
            end
            sdram_cmd_pkg::DEV_SELF_REFRESH: begin
               // Row cycle time must pass after exit before commands count
               if (cke_in) begin
                  dev_reg <= sdram_cmd_pkg::DEV_SELF_REFRESH_EXIT;
                  dev_cnt_reg <= sdram_cmd_pkg::LD_RC;
               end
            end
            sdram_cmd_pkg::DEV_POWER_DOWN: begin
               // Exit on clock enable high; the command on that edge is not taken
               if (cke_in) begin
                  dev_reg <= sdram_cmd_pkg::DEV_NORMAL;
               end
            end
            default: begin
               dev_reg <= sdram_cmd_pkg::DEV_NORMAL;
            end
         endcase
      end
   end

   // Registered status; these lag the bank state by one cycle
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         all_idle_out <= 1'b1;
         close_start_out <= '0;
         illegal_cmd_out <= 1'b0;
         power_down_out <= 1'b0;
         self_refresh_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         all_idle_out <= all_idle;
         // Pulses stand for one cycle only, just after the command edge
         close_start_out <= close_v;
         illegal_cmd_out <= ref_bad || bank_bad;
         // Levels decoded from the device state, one cycle late
         power_down_out <= (dev_reg == sdram_cmd_pkg::DEV_POWER_DOWN);
         self_refresh_out <= (dev_reg == sdram_cmd_pkg::DEV_SELF_REFRESH);
         busy_out <= (dev_reg == sdram_cmd_pkg::DEV_REFRESHING) ||
                     (dev_reg == sdram_cmd_pkg::DEV_MODE_SETTING) ||
                     (dev_reg == sdram_cmd_pkg::DEV_SELF_REFRESH_EXIT);
      end
   end
endmodule : sdram_bank_command_rules

/* File: verilog/sdram_cmd_pkg.sv */
// Shared constants, states and timing counts for the bank command tracker
package sdram_cmd_pkg;
   // Clock period in picoseconds (100 MHz)
   localparam int CLK_PERIOD_PS = 10000;

   // Device timing figures in picoseconds; only write recovery is fixed by the part
   localparam int WRITE_RECOVERY_TIME_PS = 14000;
   localparam int ROW_CYCLE_TIME_PS = 67500;
   localparam int ACT_TO_COL_TIME_PS = 22500;
   localparam int PRECHARGE_TIME_PS = 22500;
   localparam int MODE_SET_TIME_PS = 15000;

   // Least times round up to whole cycles; write recovery never below two
   localparam int WR_CYC_RAW = (WRITE_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WR_CYC_MIN = 2;
   localparam int WR_CYC = (WR_CYC_RAW > WR_CYC_MIN) ? WR_CYC_RAW : WR_CYC_MIN;
   localparam int RC_CYC = (ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RCD_CYC = (ACT_TO_COL_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RP_CYC = (PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MRD_CYC = (MODE_SET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BURST_LEN = 4;

   // Down-counter loads (count reaches zero on the last cycle)
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] LD_RC = CNT_W'(RC_CYC - 1);
   localparam logic [CNT_W-1:0] LD_RCD = CNT_W'(RCD_CYC - 1);
   localparam logic [CNT_W-1:0] LD_RP = CNT_W'(RP_CYC - 1);
   localparam logic [CNT_W-1:0] LD_WR_RP = CNT_W'(WR_CYC + RP_CYC - 1);
   localparam logic [CNT_W-1:0] LD_MRD = CNT_W'(MRD_CYC - 1);
   localparam logic [CNT_W-1:0] LD_BURST = CNT_W'(BURST_LEN - 1);

   // Bank count and row-strobe / column-strobe / write-enable command codes
   localparam int NUM_BANKS = 4;
   localparam int BANK_W = 2;
   localparam logic [2:0] CODE_NOP = 3'h7;
   localparam logic [2:0] CODE_ACTIVE = 3'h3;
   localparam logic [2:0] CODE_READ = 3'h5;
   localparam logic [2:0] CODE_WRITE = 3'h4;
   localparam logic [2:0] CODE_PRECHARGE = 3'h2;
   localparam logic [2:0] CODE_REFRESH = 3'h1;
   localparam logic [2:0] CODE_MODE_SET = 3'h0;
   localparam logic [2:0] CODE_BURST_STOP = 3'h6;

   // Per-bank state, one-hot
   localparam int BANK_ST_W = 6;
   typedef enum logic [BANK_ST_W-1:0] {
      BANK_IDLE = 6'h01,
      BANK_ACTIVATING = 6'h02,
      BANK_ACTIVE = 6'h04,
      BANK_READING = 6'h08,
      BANK_WRITING = 6'h10,
      BANK_PRECHARGING = 6'h20
   } bank_state_t;

   // Device-wide state, one-hot
   typedef enum logic [5:0] {
      DEV_NORMAL = 6'h01,
      DEV_REFRESHING = 6'h02,
      DEV_MODE_SETTING = 6'h04,
      DEV_SELF_REFRESH = 6'h08,
      DEV_SELF_REFRESH_EXIT = 6'h10,
      DEV_POWER_DOWN = 6'h20
   } dev_state_t;
endpackage : sdram_cmd_pkg
